// *** common/tbc_regs.vh ***
// register offsets, field positions, reset values and timing counts for the 10 Mb/s control block
`ifndef TBC_REGS_VH
`define TBC_REGS_VH

// ==========================================================================
// register offsets (management register index)
// ==========================================================================
`define TBC_ADDR_TEN_CTRL      5'h1a
`define TBC_ADDR_SELFTEST      5'h1b
`define TBC_ADDR_PHY_SUMMARY   5'h10
`define TBC_ADDR_PHY_CONTROL   5'h19
`define TBC_ADDR_IRQ_STATUS    5'h1e
`define TBC_ADDR_IRQ_MASK      5'h1f

// ==========================================================================
// ten_base_t_ctrl_status fields
// ==========================================================================
`define TBC_TEN_LP_OFF         7
`define TBC_TEN_FORCE_LINK     6
`define TBC_TEN_RSVD5          5
`define TBC_TEN_POLARITY       4
`define TBC_TEN_RSVD3          3
`define TBC_TEN_RSVD2          2
`define TBC_TEN_HB_OFF         1
`define TBC_TEN_JAB_OFF        0
`define TBC_TEN_RESET          8'h04

// ==========================================================================
// selftest_extension_ctrl fields
// ==========================================================================
`define TBC_ST_CNT_LSB         8
`define TBC_ST_CONT            5
`define TBC_ST_PAT_EN          4
`define TBC_ST_GAP             2
`define TBC_ST_SEL_LSB         0
`define TBC_ST_RESET           8'h00

// ==========================================================================
// phy_summary_status / phy_control fields
// ==========================================================================
`define TBC_SUM_POLARITY       12
`define TBC_SUM_LINK           0
`define TBC_PCR_ST_START       8
`define TBC_PCR_ST_STATUS      7

// ==========================================================================
// interrupt status bits
// ==========================================================================
`define TBC_IRQ_POLARITY       0
`define TBC_IRQ_CNT_SAT        1
`define TBC_IRQ_WIDTH          2

// ==========================================================================
// pattern selector codes and gap timing
// ==========================================================================
`define TBC_PAT_EOP0           2'h0
`define TBC_PAT_EOP1           2'h1
`define TBC_PAT_NLP            2'h2
`define TBC_PAT_ONES           2'h3
`define TBC_CLK_MHZ            10
`define TBC_GAP_LONG_US        15
`define TBC_GAP_SHORT_US       10
`define TBC_GAP_LONG_CYC       (`TBC_GAP_LONG_US * `TBC_CLK_MHZ)
`define TBC_GAP_SHORT_CYC      (`TBC_GAP_SHORT_US * `TBC_CLK_MHZ)

`endif

// *** design/tbc_sat_counter.v ***
// saturating error counter with synchronous clear
`timescale 1ns/1ns
`default_nettype none

module tbc_sat_counter #(
    parameter WIDTH = 8                       // counter width
) (
    input  wire             clock_i,          // block clock
    input  wire             rst_i,            // synchronous reset, high
    input  wire             clear_i,          // restart: force to zero
    input  wire             inc_i,            // one count request
    output reg  [WIDTH-1:0] count_o,          // running count
    output reg              sat_o             // pulse when max first reached
);

    wire at_max;                              // counter is full
    assign at_max = &count_o;

    // ======================================================================
    // counter: clear has priority, then sticky at max
    // ======================================================================
    always @(posedge clock_i)
    begin
        sat_o <= 1'b0;
        if (rst_i || clear_i)
        begin
            count_o <= {WIDTH{1'b0}};
        end
        else if (inc_i && !at_max)
        begin
            count_o <= count_o + {{(WIDTH-1){1'b0}}, 1'b1};
            sat_o   <= &count_o[WIDTH-1:1];   // last step onto max
        end
    end

endmodule // tbc_sat_counter

`default_nettype wire

// *** design/tbc_ten_ctrl.v ***
// 10 Mb/s control/status and self-test extension register bank
//
// Overview of operation
// - bit 7 stops normal link pulse transmit
// - bit 6 forces good 10 Mb/s link
// - polarity flag latches high on inversion
// - control register read clears both polarity copies
// - heartbeat disable acts only 10M half-duplex
// - 100M or full duplex keeps heartbeat off
// - jabber disable applies only in 10BASE-T
// - bits 15:8 count bad self-test nibbles
// - self-test restart zeroes the error counter
// - error counter sticks at its maximum
// - bit 5 sends gapless pseudo-random data
// - continuous mode works with phy_control start
// - bit 4 enables 10 Mb/s pattern generator
// - select field picks EOP0, EOP1, NLP, ones
// - gap bit selects 15 or 10 us
//
// Local design decision: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "tbc_regs.vh"

module tbc_ten_ctrl #(
    parameter CNT_WIDTH = 8                     // error counter width
) (
    input  wire        clock_i,                 // 10 MHz block clock
    input  wire        rst_i,                   // synchronous reset, high
    // management register port
    input  wire [4:0]  reg_addr_i,              // register index
    input  wire [15:0] reg_wdata_i,             // write data
    input  wire        reg_wr_i,                // write strobe
    input  wire        reg_rd_i,                // read strobe
    output reg  [15:0] reg_rdata_o,             // read data, cycle after strobe
    // line state from the 10 Mb/s datapath
    input  wire        rx_pol_inverted_i,       // polarity detector, pin domain
    input  wire        rx_link_ok_i,            // link pulse monitor, pin domain
    input  wire        speed_100_i,             // running at 100 Mb/s
    input  wire        full_duplex_i,           // configured full duplex
    input  wire        selftest_nibble_err_i,   // one bad nibble, same clock
    // function controls towards the datapath
    output reg         link_pulse_tx_en_o,      // send normal link pulses
    output reg         link_good_o,             // reported 10 Mb/s link
    output reg         heartbeat_en_o,          // heartbeat function active
    output reg         jabber_en_o,             // jabber function active
    output reg         selftest_run_o,          // self-test transmitter running
    output reg         selftest_continuous_o,   // no inter-packet gaps
    output reg         pattern_en_o,            // 10 Mb/s pattern generator on
    output reg  [1:0]  pattern_sel_o,           // pattern code
    output reg         pattern_fire_o,          // one-cycle start of a sequence
    output reg         irq_o                    // level interrupt
);

    // ======================================================================
    // storage
    // ======================================================================
    reg  [7:0]  ten_q;                          // low byte of ten_base_t_ctrl_status
    reg  [7:0]  st_q;                           // low byte of selftest_extension_ctrl
    reg  [15:0] pcr_q;                          // phy_control shadow
    reg         pol_q;                          // latched polarity flag
    reg  [`TBC_IRQ_WIDTH-1:0] irq_stat_q;       // sticky event bits
    reg  [`TBC_IRQ_WIDTH-1:0] irq_mask_q;       // enable per event
    reg  [1:0]  pol_sync_q;                     // polarity synchroniser
    reg  [1:0]  link_sync_q;                    // link synchroniser
    reg         pol_seen_q;                     // previous synced polarity
    reg  [7:0]  gap_cnt_q;                      // pattern gap timer
    wire [CNT_WIDTH-1:0] err_count;             // self-test bad nibbles
    wire        err_sat;                        // counter reached max
    wire        st_restart;                     // self-test start write

    wire pol_rise;                              // new inversion seen
    wire rd_ten;                                // read of control register
    wire rd_irq;                                // read of interrupt status
    wire half10;                                // 10 Mb/s half-duplex
    // gap loads: the fire cycle is part of the period, so load one less
    localparam [31:0] GAP_LONG_LOAD  = `TBC_GAP_LONG_CYC - 1;   // 15 us period
    localparam [31:0] GAP_SHORT_LOAD = `TBC_GAP_SHORT_CYC - 1;  // 10 us period

    assign rd_ten   = reg_rd_i && (reg_addr_i == `TBC_ADDR_TEN_CTRL);
    assign rd_irq   = reg_rd_i && (reg_addr_i == `TBC_ADDR_IRQ_STATUS);
    assign pol_rise = pol_sync_q[1] && !pol_seen_q;
    assign half10   = !speed_100_i && !full_duplex_i;
    // writing the start bit restarts a run and must zero the counter
    assign st_restart = reg_wr_i && (reg_addr_i == `TBC_ADDR_PHY_CONTROL)
                        && reg_wdata_i[`TBC_PCR_ST_START];

    // ======================================================================
    // pin synchronisers: second stage is the only reader of the first
    // ======================================================================
    always @(posedge clock_i)
    begin
        if (rst_i)
        begin
            pol_sync_q  <= 2'h0;
            link_sync_q <= 2'h0;
            pol_seen_q  <= 1'b0;
        end
        else
        begin
            pol_sync_q  <= {pol_sync_q[0], rx_pol_inverted_i};
            link_sync_q <= {link_sync_q[0], rx_link_ok_i};
            pol_seen_q  <= pol_sync_q[1];
        end
    end

    // ======================================================================
    // control registers
    // ======================================================================
    always @(posedge clock_i)
    begin
        if (rst_i)
        begin
            ten_q      <= `TBC_TEN_RESET;
            st_q       <= `TBC_ST_RESET;
            pcr_q      <= 16'h0000;
            irq_mask_q <= {`TBC_IRQ_WIDTH{1'b0}};
        end
        else if (reg_wr_i)
        begin
            case (reg_addr_i)
                `TBC_ADDR_TEN_CTRL:
                    ten_q <= reg_wdata_i[7:0];   // reserved bits stored as written
                `TBC_ADDR_SELFTEST:
                    st_q  <= reg_wdata_i[7:0];   // upper count field is read-only
                `TBC_ADDR_PHY_CONTROL:
                    pcr_q <= reg_wdata_i;
                `TBC_ADDR_IRQ_MASK:
                    irq_mask_q <= reg_wdata_i[`TBC_IRQ_WIDTH-1:0];
                default:
                    pcr_q <= pcr_q;              // unmapped: write ignored
            endcase
        end
    end

    // ======================================================================
    // polarity flag: latch high, cleared only by control register read
    // ======================================================================
    always @(posedge clock_i)
    begin
        if (rst_i)
        begin
            pol_q <= 1'b0;
        end
        else if (pol_sync_q[1])
        begin
            pol_q <= 1'b1;                       // set beats read clear
        end
        else if (rd_ten)
        begin
            pol_q <= 1'b0;                       // both copies share this flop
        end
    end

    // ======================================================================
    // self-test error counter
    // ======================================================================
    tbc_sat_counter #(
        .WIDTH   (CNT_WIDTH)
    ) u_err_cnt (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .clear_i (st_restart),
        .inc_i   (selftest_nibble_err_i && selftest_run_o),
        .count_o (err_count),
        .sat_o   (err_sat)
    );

    // ======================================================================
    // interrupt status: events set, read clears, set wins
    // ======================================================================
    always @(posedge clock_i)
    begin
        if (rst_i)
        begin
            irq_stat_q <= {`TBC_IRQ_WIDTH{1'b0}};
            irq_o      <= 1'b0;
        end
        else
        begin
            irq_stat_q <= (rd_irq ? {`TBC_IRQ_WIDTH{1'b0}} : irq_stat_q)
                          | {err_sat, pol_rise};
            irq_o      <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ======================================================================
    // read data: one cycle after the strobe, zero otherwise
    // ======================================================================
    always @(posedge clock_i)
    begin
        if (rst_i || !reg_rd_i)
        begin
            reg_rdata_o <= 16'h0000;
        end
        else
        begin
            case (reg_addr_i)
                `TBC_ADDR_TEN_CTRL:
                    reg_rdata_o <= {8'h00, ten_q[7:5], pol_q, ten_q[3:0]};
                `TBC_ADDR_SELFTEST:
                    reg_rdata_o <= {err_count, st_q};
                `TBC_ADDR_PHY_SUMMARY:              // mirror, read does not clear
                    reg_rdata_o <= {3'h0, pol_q, 11'h000, link_good_o};
                `TBC_ADDR_PHY_CONTROL:
                    reg_rdata_o <= {pcr_q[15:8], selftest_run_o, pcr_q[6:0]};
                `TBC_ADDR_IRQ_STATUS:
                    reg_rdata_o <= {14'h0000, irq_stat_q};
                `TBC_ADDR_IRQ_MASK:
                    reg_rdata_o <= {14'h0000, irq_mask_q};
                default:
                    reg_rdata_o <= 16'h0000;     // unmapped reads zero
            endcase
        end
    end

    // ======================================================================
    // function controls
    // ======================================================================
    always @(posedge clock_i)
    begin
        if (rst_i)
        begin
            link_pulse_tx_en_o    <= 1'b1;
            link_good_o           <= 1'b0;
            heartbeat_en_o        <= 1'b0;
            jabber_en_o           <= 1'b1;
            selftest_run_o        <= 1'b0;
            selftest_continuous_o <= 1'b0;
            pattern_en_o          <= 1'b0;
            pattern_sel_o         <= `TBC_PAT_EOP0;
        end
        else
        begin
            link_pulse_tx_en_o <= !ten_q[`TBC_TEN_LP_OFF];
            link_good_o        <= ten_q[`TBC_TEN_FORCE_LINK] || link_sync_q[1];
            // heartbeat only exists in 10 Mb/s half duplex
            heartbeat_en_o     <= half10 && !ten_q[`TBC_TEN_HB_OFF];
            // jabber disable only honoured at 10 Mb/s; 100 Mb/s keeps its own
            jabber_en_o        <= speed_100_i || !ten_q[`TBC_TEN_JAB_OFF];
            selftest_run_o     <= pcr_q[`TBC_PCR_ST_START];
            // continuous only while a run is started
            selftest_continuous_o <= st_q[`TBC_ST_CONT] && pcr_q[`TBC_PCR_ST_START];
            pattern_en_o       <= st_q[`TBC_ST_PAT_EN];
            pattern_sel_o      <= st_q[1:0];
        end
    end

    // ======================================================================
    // pattern sequence timer: gap between sequences, ones run gapless
    // ======================================================================
    always @(posedge clock_i)
    begin
        if (rst_i || !pattern_en_o)
        begin
            gap_cnt_q      <= 8'h00;
            pattern_fire_o <= 1'b0;
        end
        else if (pattern_sel_o == `TBC_PAT_ONES)
        begin
            gap_cnt_q      <= 8'h00;             // constant tone, no sequences
            pattern_fire_o <= 1'b0;
        end
        else if (gap_cnt_q == 8'h00)
        begin
            gap_cnt_q      <= st_q[`TBC_ST_GAP] ? GAP_LONG_LOAD[7:0]
                                                : GAP_SHORT_LOAD[7:0];
            pattern_fire_o <= 1'b1;
        end
        else
        begin
            gap_cnt_q      <= gap_cnt_q - 8'h01;
            pattern_fire_o <= 1'b0;
        end
    end

endmodule // tbc_ten_ctrl

`default_nettype wire

// *** test/tbc_ten_ctrl_props.sv ***
// concurrent checks on the ports of the 10 Mb/s control register bank
`timescale 1ns/1ns
`default_nettype none
module tbc_ten_ctrl_props (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic [4:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [15:0] reg_rdata_o,
    input  wire logic        rx_pol_inverted_i,
    input  wire logic        speed_100_i,
    input  wire logic        full_duplex_i,
    input  wire logic        link_pulse_tx_en_o,
    input  wire logic        link_good_o,
    input  wire logic        heartbeat_en_o,
    input  wire logic        jabber_en_o,
    input  wire logic        selftest_run_o,
    input  wire logic        pattern_en_o,
    input  wire logic [1:0]  pattern_sel_o
);
    // =====================================================
    // decoded strobes
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    wire w1a = reg_wr_i && reg_addr_i == 5'h1a;  // control write
    wire r1a = reg_rd_i && reg_addr_i == 5'h1a;  // control read
    wire lo  = !speed_100_i && !full_duplex_i;   // 10M half duplex
    // =====================================================
    // properties; ##2 leaves room for the output register
    chk_lp_follow: assert property (
        w1a |-> ##2 link_pulse_tx_en_o == !$past(reg_wdata_i[7], 2)) else $error("link pulse enable wrong");
    chk_force_link: assert property (
        w1a && reg_wdata_i[6] |-> ##2 link_good_o) else $error("forced link not reported");
    chk_hb_half: assert property (
        (w1a && lo) ##1 lo[*2] |-> heartbeat_en_o == !$past(reg_wdata_i[1], 2)) else $error("heartbeat wrong");
    chk_hb_fast: assert property (
        heartbeat_en_o |-> !$past(speed_100_i) && !$past(full_duplex_i)) else $error("heartbeat on when fast");
    chk_jab_fast: assert property (
        speed_100_i |=> jabber_en_o) else $error("jabber off at 100M");
    chk_jab_slow: assert property (
        (w1a && !speed_100_i) ##1 (!speed_100_i)[*2] |-> jabber_en_o == !$past(reg_wdata_i[0], 2))
        else $error("jabber enable wrong");
    chk_pol_latch: assert property (
        rx_pol_inverted_i[*5] ##0 r1a |=> reg_rdata_o[4]) else $error("polarity flag not set");
    chk_pol_clear: assert property (
        (!rx_pol_inverted_i)[*5] ##0 r1a ##1 r1a |=> !reg_rdata_o[4]) else $error("polarity flag not cleared");
    chk_run_start: assert property (
        reg_wr_i && reg_addr_i == 5'h19 && reg_wdata_i[8] |-> ##2 selftest_run_o) else $error("self-test idle");
    chk_pat_follow: assert property (
        reg_wr_i && reg_addr_i == 5'h1b |-> ##2 pattern_en_o == $past(reg_wdata_i[4], 2)
        && pattern_sel_o == $past(reg_wdata_i[1:0], 2)) else $error("pattern controls wrong");
endmodule // tbc_ten_ctrl_props
`default_nettype wire

// *** test/tbc_link_partner.sv ***
// far-end model: line polarity, link pulses and bad self-test nibbles
`timescale 1ns/1ns
`default_nettype none
module tbc_link_partner (
    input  wire logic       clock_i,   // bench clock
    input  wire logic       invert_i,  // pair wired swapped
    input  wire logic       link_i,    // far end sends link pulses
    input  wire logic       slow_i,    // pace bad nibbles every other cycle
    input  wire logic [9:0] errs_i,    // burst length
    input  wire logic       load_i,    // start a burst
    output wire logic       pol_inv_o, // seen polarity
    output wire logic       link_ok_o, // seen link activity
    output logic            nib_err_o  // one bad nibble
);
    // =====================================================
    // line levels follow the far end directly
    logic [9:0] left_q = 10'h000; // nibbles still to corrupt
    logic       ph_q   = 1'b0;    // pacing phase
    assign pol_inv_o = invert_i;
    assign link_ok_o = link_i;
    initial nib_err_o = 1'b0;
    // burst engine; slow mode shows the counter is not tied to back-to-back pulses
    always @(posedge clock_i)
    begin
        ph_q <= ~ph_q;
        nib_err_o <= (left_q != 10'h000) && (!slow_i || ph_q);
        if (load_i)
            left_q <= errs_i;
        else if ((left_q != 10'h000) && (!slow_i || ph_q))
            left_q <= left_q - 10'h001;
    end
endmodule // tbc_link_partner
`default_nettype wire

// *** test/tbc_ten_ctrl_tb.sv ***
// self-checking bench for the 10 Mb/s control register bank
`timescale 1ns/1ns
`default_nettype none
module tbc_ten_ctrl_tb;
    // =====================================================
    // stimulus and observed signals
    logic clock_i = 1'b0, rst_i = 1'b1;
    logic [4:0] reg_addr_i = 5'h00;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, speed_100_i = 1'b0, full_duplex_i = 1'b0;
    logic inv = 1'b0, lnk = 1'b0, pace = 1'b0, load = 1'b0;
    logic [9:0] errs = 10'h000;
    logic [7:0] v;
    logic [31:0] seed = 32'h68317b36;
    wire logic rx_pol_inverted_i, rx_link_ok_i, selftest_nibble_err_i;
    wire logic [15:0] reg_rdata_o;
    wire logic link_pulse_tx_en_o, link_good_o, heartbeat_en_o, jabber_en_o, selftest_run_o;
    wire logic selftest_continuous_o, pattern_en_o, pattern_fire_o, irq_o;
    wire logic [1:0] pattern_sel_o;
    int miscompares = 0, checked = 0, cycles = 0, fires = 0, i, f0, n0, n1;
    always #50 clock_i = ~clock_i;
    tbc_ten_ctrl #(.CNT_WIDTH(8)) i_tbc_ten_ctrl (.clock_i, .rst_i, .reg_addr_i, .reg_wdata_i,
        .reg_wr_i, .reg_rd_i, .reg_rdata_o, .rx_pol_inverted_i, .rx_link_ok_i, .speed_100_i,
        .full_duplex_i, .selftest_nibble_err_i, .link_pulse_tx_en_o, .link_good_o, .heartbeat_en_o,
        .jabber_en_o, .selftest_run_o, .selftest_continuous_o, .pattern_en_o, .pattern_sel_o,
        .pattern_fire_o, .irq_o);
    tbc_link_partner i_tbc_link_partner (.clock_i, .invert_i(inv), .link_i(lnk), .slow_i(pace),
        .errs_i(errs), .load_i(load), .pol_inv_o(rx_pol_inverted_i), .link_ok_o(rx_link_ok_i),
        .nib_err_o(selftest_nibble_err_i));
    // =====================================================
    // helpers; the timeout sits about three times above the roughly 6400 cycles needed
    always @(posedge clock_i)
    begin
        cycles++;
        if (pattern_fire_o === 1'b1)
            fires++;
        if (cycles == 20000)
        begin
            miscompares++;
            end_of_test();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [3:0] exp_ctl(input logic [7:0] w, input logic s, input logic f);
        return {~w[7], w[6], ~w[1] & ~s & ~f, s | ~w[0]};
    endfunction
    task automatic end_of_test;
        $display("counts: checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] w);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_wdata_i <= w;
        reg_wr_i <= 1'b1;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rdchk(input logic [4:0] a, input logic [15:0] e, input logic [15:0] m);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        #1;
        chk(reg_rdata_o & m, e);
        @(posedge clock_i); // hand back on an edge so callers drive there
    endtask
    task automatic burst(input logic [9:0] n, input logic slow);
        @(posedge clock_i);
        errs <= n;
        pace <= slow;
        load <= 1'b1;
        @(posedge clock_i);
        load <= 1'b0;
        cyc(2 * n + 4);
    endtask
    task automatic span(output int n);
        n = 0;
        do begin @(posedge clock_i); #1; n++; end while (pattern_fire_o !== 1'b1 && n < 2000);
        n = 0;
        do begin @(posedge clock_i); #1; n++; end while (pattern_fire_o !== 1'b1 && n < 2000);
    endtask
    // =====================================================
    // main sequence
    initial
    begin
        cyc(16);
        rst_i <= 1'b0;
        rdchk(5'h1a, 16'h0004, 16'hffff);
        rdchk(5'h1b, 16'h0000, 16'hffff);
        rdchk(5'h05, 16'h0000, 16'hffff);
        chk({14'h0, link_pulse_tx_en_o, jabber_en_o}, 16'h0003);
        $display("test reset done");
        // control bits: two corners, then random, polarity bit written but read only
        for (i = 0; i < 12; i++)
        begin
            seed = lfsr(seed);
            v = (i == 0) ? 8'hd7 : (i == 1) ? 8'h04 : ((seed[7:0] & 8'hd3) | 8'h04);
            speed_100_i <= (i > 1) & seed[8];
            full_duplex_i <= (i > 1) & seed[9];
            wr(5'h1a, {8'h00, v});
            cyc(3);
            chk({12'h0, link_pulse_tx_en_o, link_good_o, heartbeat_en_o, jabber_en_o},
                {12'h0, exp_ctl(v, speed_100_i, full_duplex_i)});
            rdchk(5'h1a, {8'h00, v & 8'hef}, 16'hffff);
        end
        speed_100_i <= 1'b0;
        full_duplex_i <= 1'b0;
        wr(5'h1a, 16'h0004);
        lnk <= 1'b1;
        cyc(5);
        chk({15'h0, link_good_o}, 16'h0001);
        lnk <= 1'b0;
        $display("test control done");
        // polarity latch, mirror and interrupt
        wr(5'h1f, 16'h0001);
        inv <= 1'b1;
        cyc(6);
        chk({15'h0, irq_o}, 16'h0001);
        rdchk(5'h10, 16'h1000, 16'h1000);
        rdchk(5'h10, 16'h1000, 16'h1000);
        rdchk(5'h1a, 16'h0010, 16'h0010);
        inv <= 1'b0;
        cyc(4);
        reg_addr_i <= 5'h1a;
        reg_rd_i <= 1'b1;
        @(posedge clock_i);
        #1;
        chk(reg_rdata_o & 16'h0010, 16'h0010);
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        #1;
        chk(reg_rdata_o & 16'h0010, 16'h0000);
        rdchk(5'h10, 16'h0000, 16'h1000);
        rdchk(5'h1e, 16'h0001, 16'h0003);
        cyc(2);
        chk({15'h0, irq_o}, 16'h0000);
        wr(5'h1f, 16'h0000);
        inv <= 1'b1;
        cyc(6);
        chk({15'h0, irq_o}, 16'h0000);
        inv <= 1'b0;
        cyc(4);
        rdchk(5'h1e, 16'h0001, 16'h0001);
        rdchk(5'h1a, 16'h0010, 16'h0010);
        $display("test polarity done");
        // error counter: count, saturate, restart
        wr(5'h19, 16'h0100);
        cyc(2);
        chk({15'h0, selftest_run_o}, 16'h0001);
        burst(10'd37, 1'b1);
        rdchk(5'h1b, 16'h2500, 16'hff00);
        burst(10'd300, 1'b0);
        rdchk(5'h1b, 16'hff00, 16'hff00);
        rdchk(5'h1e, 16'h0002, 16'h0002);
        wr(5'h19, 16'h0100);
        cyc(2);
        rdchk(5'h1b, 16'h0000, 16'hff00);
        wr(5'h1a, 16'h0005); // jabber off first
        wr(5'h1b, 16'hff20);
        cyc(3);
        chk({15'h0, selftest_continuous_o}, 16'h0001);
        rdchk(5'h1b, 16'h0020, 16'hffff);
        wr(5'h19, 16'h0000);
        cyc(3);
        chk({14'h0, selftest_run_o, selftest_continuous_o}, 16'h0000);
        $display("test self-test done");
        // pattern codes, gap and disable
        for (i = 0; i < 4; i++)
        begin
            wr(5'h1b, 16'h0010 | 16'(i));
            cyc(3);
            chk({13'h0, pattern_en_o, pattern_sel_o}, 16'h0004 | 16'(i));
            f0 = fires;
            cyc(1000);
            chk(16'(fires != f0), 16'(i != 3));
        end
        wr(5'h1b, 16'h0010);
        span(n0);
        wr(5'h1b, 16'h0014);
        span(n1);
        chk(16'(n1 - n0), 16'h0032);
        wr(5'h1b, 16'h0000);
        f0 = fires;
        cyc(1000);
        chk(16'(fires - f0), 16'h0000);
        $display("test pattern done");
        end_of_test();
    end
endmodule // tbc_ten_ctrl_tb
bind tbc_ten_ctrl tbc_ten_ctrl_props i_props (.clock_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .rx_pol_inverted_i, .speed_100_i, .full_duplex_i, .link_pulse_tx_en_o,
    .link_good_o, .heartbeat_en_o, .jabber_en_o, .selftest_run_o, .pattern_en_o, .pattern_sel_o);
`default_nettype wire
